// ==== src/dpsram_port_pkg.sv ====
// shared constants for one port of the synchronous dual-port ram
`default_nettype none
package dpsram_port_pkg;
  // word and lane layout
  localparam int DATA_W = 18;
  localparam int LANE_W = 9;
  localparam int LANE_CNT = 2;
  localparam int LANE_LOWER = 0;
  localparam int LANE_UPPER = 1;
  // full depth address width and the smallest address width a port accepts
  localparam int ADDR_W_FULL = 18;
  localparam int ADDR_W_MIN = 1;
  // latency select encoding: high picks the pipelined output stage
  localparam logic LAT_FLOW = 1'h0;
  localparam logic LAT_PIPE = 1'h1;
  // reset values of counter, repeat reload, lane drives and read data
  localparam logic [ADDR_W_FULL-1:0] ADDR_RESET = 18'h0_0000;
  localparam logic [LANE_CNT-1:0] LANES_OFF = 2'h0;
  localparam logic [DATA_W-1:0] DATA_RESET = 18'h0_0000;
endpackage
`default_nettype wire

// ==== src/dpsram_lane_mem.sv ====
// byte-lane word memory with registered read data
`default_nettype none
module dpsram_lane_mem
  import dpsram_port_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_FULL
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [LANE_CNT-1:0] wr_lane,
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  output logic [DATA_W-1:0] rd_data
);
  typedef struct packed {
    logic [DATA_W-1:0] rd_data;
  } mem_state_s;

  // the arrays stay outside the struct: too large to be packed state
  logic [DATA_W-1:0] rd_word;
  mem_state_s s_reg;
  mem_state_s s_next;

  // read port: old content on a read, hold otherwise
  always_comb begin
    s_next = s_reg;
    if (rd_en) begin
      s_next.rd_data = rd_word;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_reg.rd_data <= DATA_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // one array per lane so each has a single writing process; no reset
  for (genvar g = 0; g < LANE_CNT; g++) begin : g_lane
    logic [LANE_W-1:0] lane_words [2**ADDR_W];
    always_ff @(posedge clk) begin
      if (wr_lane[g]) begin
        lane_words[addr] <= wr_data[g*LANE_W +: LANE_W];
      end
    end
    assign rd_word[g*LANE_W +: LANE_W] = lane_words[addr];
  end

  assign rd_data = s_reg.rd_data;
endmodule
`default_nettype wire

// ==== src/dpsram_port_ctrl.sv ====
// access logic of one port: selects, lanes, latency, burst counter
`default_nettype none
// Functional notes
// - write cycle stores each lane whose active-low lane enable is low.
// - upper lane enable covers bits 9..17, lower covers bits 0..8.
// - read cycle with output enable low drives only the enabled lanes.
// - output enable acts asynchronously; high floats both lanes.
// - pipelined mode delays deselect of selects and lanes by two cycles.
// - pipelined mode presents read data one cycle after flow-through.
// - address load with repeat high uses and stores external address.
// - repeat low restores the last loaded address, overriding load and count.
// - load, count and repeat all high reuse the previous address.
// - count enable low, load and repeat high increment the address.
// - counter advances regardless of selects and lane enables.
// - load and repeat act even while the port is deselected.
module dpsram_port_ctrl
  import dpsram_port_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_FULL
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic select_active_low,
  input wire logic select_active_high,
  input wire logic read_write,
  input wire logic output_enable_n,
  input wire logic upper_lane_enable_n,
  input wire logic lower_lane_enable_n,
  input wire logic address_load_n,
  input wire logic count_enable_n,
  input wire logic repeat_n,
  input wire logic output_latency_select,
  input wire logic [ADDR_W-1:0] ext_addr,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic [DATA_W-1:0] data_oe,
  output logic power_down,
  output logic [ADDR_W-1:0] internal_addr
);
  // depth beyond the full part or an empty counter cannot be served
  if (ADDR_W < ADDR_W_MIN || ADDR_W > ADDR_W_FULL) begin : g_bad_width
    $error("address width out of range");
  end

  typedef struct packed {
    logic [ADDR_W-1:0] cnt;
    logic [ADDR_W-1:0] reload;
    logic [LANE_CNT-1:0] drv1;
    logic [LANE_CNT-1:0] drv2;
    logic [DATA_W-1:0] dout_pipe;
    logic standby1;
    logic standby2;
  } port_state_s;

  port_state_s s_reg;
  port_state_s s_next;
  logic selected;
  logic [LANE_CNT-1:0] lane_on;
  logic [LANE_CNT-1:0] wr_lane;
  logic [LANE_CNT-1:0] drv_sel;
  logic rd_en;
  logic [ADDR_W-1:0] addr_used;
  logic [DATA_W-1:0] rd_data;

  // lane vector in index order lower, upper
  // lane to bit mapping
  assign lane_on[LANE_LOWER] = ~lower_lane_enable_n;
  assign lane_on[LANE_UPPER] = ~upper_lane_enable_n;
  assign selected = ~select_active_low & select_active_high;

  // address source; repeat outranks load, load outranks counting
  always_comb begin
    s_next = s_reg;
    addr_used = s_reg.cnt;
    if (!repeat_n) begin
      addr_used = s_reg.reload;
    end else if (!address_load_n) begin
      addr_used = ext_addr;
      s_next.reload = ext_addr;
    end else if (!count_enable_n) begin
      addr_used = ADDR_W'(s_reg.cnt + 1'b1);
    end
    s_next.cnt = addr_used;
    // lane write strobes, gated by select
    // no store during reset: the counter is forced then, so the address would be stale
    wr_lane = (selected && !read_write && !srst) ? lane_on : LANES_OFF;
    rd_en = selected && read_write;
    // read lanes become drive lanes after the edge
    s_next.drv1 = rd_en ? lane_on : LANES_OFF;
    // second stage of the double-registered enables
    s_next.drv2 = s_reg.drv1;
    s_next.dout_pipe = rd_data;
    // low power flag follows the deselect
    s_next.standby1 = ~selected;
    s_next.standby2 = s_reg.standby1;
  end

  // counter and reload clear on reset so simulation never sees unknowns
  always_ff @(posedge clk) begin
    if (srst) begin
      s_reg.cnt <= ADDR_W'(ADDR_RESET);
      s_reg.reload <= ADDR_W'(ADDR_RESET);
      s_reg.drv1 <= LANES_OFF;
      s_reg.drv2 <= LANES_OFF;
      s_reg.dout_pipe <= DATA_RESET;
      s_reg.standby1 <= 1'b1;
      s_reg.standby2 <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  dpsram_lane_mem #(
    .ADDR_W(ADDR_W)
  ) u_mem (
    .clk(clk),
    .srst(srst),
    .wr_lane(wr_lane),
    .rd_en(rd_en),
    .addr(addr_used),
    .wr_data(data_in),
    .rd_data(rd_data)
  );

  // extra output stage in pipelined mode
  assign data_out = (output_latency_select == LAT_PIPE) ? s_reg.dout_pipe : rd_data;
  assign drv_sel = (output_latency_select == LAT_PIPE) ? s_reg.drv2 : s_reg.drv1;
  assign power_down = (output_latency_select == LAT_PIPE) ? s_reg.standby2 : s_reg.standby1;
  assign internal_addr = s_reg.cnt;

  // output enable gates the drivers with no clock involved
  for (genvar g = 0; g < LANE_CNT; g++) begin : g_oe
    assign data_oe[g*LANE_W +: LANE_W] = {LANE_W{drv_sel[g] & ~output_enable_n}};
  end

  // checks on the port behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_write_lane;
    selected && !read_write && !lower_lane_enable_n && upper_lane_enable_n
      |-> wr_lane[LANE_LOWER] && !wr_lane[LANE_UPPER];
  endproperty
  a_write_lane: assert property (p_write_lane) else $error("write lane strobe wrong");

  property p_read_drive;
    output_latency_select == LAT_FLOW && selected && read_write && !upper_lane_enable_n
      && lower_lane_enable_n ##1 !output_enable_n && $stable(output_latency_select)
      |-> data_oe[DATA_W-1] && !data_oe[0];
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read lane drive wrong");

  property p_oe_async;
    output_enable_n |-> data_oe == '0;
  endproperty
  a_oe_async: assert property (p_oe_async) else $error("data driven with output enable high");

  property p_deselect_flow;
    output_latency_select == LAT_FLOW && !selected ##1 output_latency_select == LAT_FLOW
      |-> data_oe == '0 && power_down;
  endproperty
  a_deselect_flow: assert property (p_deselect_flow) else $error("deselect not honoured");

  property p_deselect_pipe;
    output_latency_select == LAT_PIPE && rd_en ##1 !selected
      ##1 output_latency_select == LAT_PIPE |-> !power_down ##1 power_down && data_oe == '0;
  endproperty
  a_deselect_pipe: assert property (p_deselect_pipe) else $error("pipelined deselect timing wrong");

  property p_pipe_latency;
    output_latency_select == LAT_PIPE ##1 output_latency_select == LAT_PIPE
      |-> data_out == $past(rd_data);
  endproperty
  a_pipe_latency: assert property (p_pipe_latency) else $error("pipelined data not one cycle late");

  property p_load;
    repeat_n && !address_load_n |=> s_reg.cnt == $past(ext_addr) && s_reg.reload == $past(ext_addr);
  endproperty
  a_load: assert property (p_load) else $error("address load not taken");

  property p_repeat;
    !address_load_n && repeat_n ##1 !repeat_n
      |=> s_reg.cnt == $past(ext_addr, 2);
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat did not restore loaded address");

  property p_hold;
    address_load_n && count_enable_n && repeat_n |=> $stable(s_reg.cnt);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved while held");

  property p_count_deselected;
    address_load_n && !count_enable_n && repeat_n && !selected
      |=> s_reg.cnt == ADDR_W'($past(s_reg.cnt) + 1'b1);
  endproperty
  a_count_deselected: assert property (p_count_deselected) else $error("counter did not advance");

  property p_load_deselected;
    !selected && !address_load_n && repeat_n |=> $past(ext_addr) == internal_addr;
  endproperty
  a_load_deselected: assert property (p_load_deselected) else $error("load ignored when deselected");

  property p_wrap;
    s_reg.cnt == '1 && address_load_n && !count_enable_n && repeat_n |=> s_reg.cnt == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");
endmodule
`default_nettype wire

// ==== dv/dpsram_host_model.sv ====
// host master model: drives the command, address and write data pins of one port
`default_nettype none
module dpsram_host_model
  import dpsram_port_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic fill,
  output logic select_active_low,
  output logic select_active_high,
  output logic read_write,
  output logic output_enable_n,
  output logic upper_lane_enable_n,
  output logic lower_lane_enable_n,
  output logic address_load_n,
  output logic count_enable_n,
  output logic repeat_n,
  output logic [ADDR_W-1:0] ext_addr,
  output logic [DATA_W-1:0] data_in
);
  int seed = 32'hb499;
  logic [31:0] r;
  logic [ADDR_W-1:0] fill_addr = '0;
  // pins parked deselected until the first falling edge
  initial begin
    {select_active_low, select_active_high, read_write, output_enable_n, upper_lane_enable_n,
     lower_lane_enable_n, address_load_n, count_enable_n, repeat_n, ext_addr,
     data_in} = {(9 + ADDR_W + DATA_W){1'b0}};
  end
  // commands move on the falling edge, well clear of the sampling edge
  always @(negedge clk) begin
    r = $random(seed);
    data_in <= DATA_W'($random(seed));
    if (fill) begin
      // known address loaded before any repeat
      {select_active_low, select_active_high, read_write, output_enable_n} <= 4'h5;
      {upper_lane_enable_n, lower_lane_enable_n, address_load_n, count_enable_n, repeat_n} <= 5'h03;
      ext_addr <= fill_addr;
      fill_addr <= fill_addr + 1'b1;
    end else begin
      // mostly selected, with rarer loads and repeats so bursts get long
      select_active_low <= r[0] & r[1];
      select_active_high <= r[2] | r[3];
      read_write <= r[4];
      output_enable_n <= r[5] & r[6];
      upper_lane_enable_n <= r[7];
      lower_lane_enable_n <= r[8];
      address_load_n <= r[9] | r[10];
      count_enable_n <= r[11];
      repeat_n <= r[12] | r[13] | r[14];
      ext_addr <= ADDR_W'(r[31:16]);
    end
  end
endmodule
`default_nettype wire

// ==== dv/dual_port_sram_port_control_test.sv ====
// self-checking bench for one port of the synchronous dual-port ram
`default_nettype none
module dual_port_sram_port_control_test
  import dpsram_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int AW = 8;
  logic clk, srst, fill, lat, lq, run, sel, power_down, s1p, s2p;
  logic select_active_low, select_active_high, read_write, output_enable_n, repeat_n;
  logic upper_lane_enable_n, lower_lane_enable_n, address_load_n, count_enable_n;
  logic [AW-1:0] ext_addr, internal_addr, ea, rl;
  logic [DATA_W-1:0] data_in, data_out, data_oe, s1d, s2d, eoe, m;
  logic [DATA_W-1:0] mem [2**AW];
  logic [1:0] s1l, s2l, el;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  dpsram_host_model #(.ADDR_W(AW)) host_u (.clk, .fill, .select_active_low, .select_active_high,
    .read_write, .output_enable_n, .upper_lane_enable_n, .lower_lane_enable_n, .address_load_n,
    .count_enable_n, .repeat_n, .ext_addr, .data_in);
  dpsram_port_ctrl #(.ADDR_W(AW)) dut_u (.clk, .srst, .select_active_low, .select_active_high,
    .read_write, .output_enable_n, .upper_lane_enable_n, .lower_lane_enable_n, .address_load_n,
    .count_enable_n, .repeat_n, .output_latency_select(lat), .ext_addr, .data_in, .data_out,
    .data_oe, .power_down, .internal_addr);
  task automatic chk_vec(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // reference model, stepped on each sampling edge
  always @(posedge clk) begin
    lq = lat;
    if (srst) begin
      {ea, rl, s1l, s2l, s1p, s2p} = {{(2 * AW + 4){1'b0}}, 2'h3};
    end else begin
      // priority of the address sources, wrapping in depth
      if (!repeat_n) ea = rl;
      else if (!address_load_n) {ea, rl} = {ext_addr, ext_addr};
      else if (!count_enable_n) ea = ea + 1'b1;
      sel = !select_active_low && select_active_high;
      {s2l, s2d, s2p} = {s1l, s1d, s1p};
      s1p = !sel;
      s1l = LANES_OFF;
      m = {{LANE_W{!upper_lane_enable_n}}, {LANE_W{!lower_lane_enable_n}}};
      if (sel && !read_write) mem[ea] = (mem[ea] & ~m) | (data_in & m);
      if (sel && read_write) {s1l, s1d} = {!upper_lane_enable_n, !lower_lane_enable_n, mem[ea]};
    end
  end
  // outputs checked mid-cycle, before the host moves the pins
  always @(negedge clk) begin
    if (run) begin
      el = lq ? s2l : s1l;
      eoe = {{LANE_W{el[1]}}, {LANE_W{el[0]}}} & {DATA_W{!output_enable_n}};
      chk_vec(data_oe, eoe);
      chk_vec(data_out & eoe, (lq ? s2d : s1d) & eoe);
      chk_vec(DATA_W'(internal_addr), DATA_W'(ea));
      chk_bit(power_down, lq ? s2p : s1p);
    end
  end
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // hang guard: the sequence needs about 1100 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1500) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    srst = 1'b1;
    fill = 1'b1;
    lat = LAT_FLOW;
    run = 1'b0;
    @(posedge clk);
    run = 1'b1;
    repeat (3) @(negedge clk);
    // non-blocking so checker and host at this edge still see the old values
    srst <= 1'b0;
    repeat (2**AW + 4) @(negedge clk);
    fill <= 1'b0;
    repeat (400) @(negedge clk);
    // pipelined pass after a reset in mid-run; memory keeps its contents
    srst <= 1'b1;
    lat <= LAT_PIPE;
    repeat (3) @(negedge clk);
    srst <= 1'b0;
    repeat (400) @(negedge clk);
    close_out();
  end
endmodule
`default_nettype wire
